//--- phy_ctrl_pkg.sv
package phy_ctrl_pkg;

	// ------------------------------------------------------------------
	// Register map and field layout
	// ------------------------------------------------------------------

	localparam int          REG_ADDR_W         = 5;      // Management register address width.
	localparam int          REG_DATA_W         = 16;     // Management register data width.
	localparam logic [4:0]  BASIC_CONTROL_ADDR = 5'h00;  // Offset of basic_control.

	localparam int          SOFT_RESET_BIT     = 15;     // Self-clearing soft reset.
	localparam int          LOOPBACK_BIT       = 14;     // Loopback mode.
	localparam int          SPEED_BIT          = 13;     // Manual speed, 1 = 100 Mbps.
	localparam int          AN_ENABLE_BIT      = 12;     // Auto-negotiation enable.
	localparam int          POWER_DOWN_BIT     = 11;     // Power-down mode.
	localparam int          ISOLATE_BIT        = 10;     // Isolation from the MAC interface.
	localparam int          AN_RESTART_BIT     = 9;      // Self-clearing negotiation restart.
	localparam int          DUPLEX_BIT         = 8;      // Manual duplex, 1 = full.
	localparam int          COL_TEST_BIT       = 7;      // Collision indicator test.

	localparam logic [15:0] ZERO_WORD          = 16'h0000; // Reserved bits and unmapped reads.
	localparam int          STRAP_COUNT        = 4;      // Number of strapping pins.

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------

	// Strapping pins as sampled on the device clock.
	typedef struct packed {
		logic speed_strap;           // 1 = default 100 Mbps.
		logic autoneg_enable_strap;  // 1 = default negotiation on.
		logic isolate_strap;         // 1 = default isolated.
		logic duplex_strap;          // Inverse of the default duplex.
	} strap_t;

	// Latch phase: straps are loaded on the cycle after any reset.
	typedef enum logic {
		ST_LATCH = 1'b0,
		ST_RUN   = 1'b1
	} mode_t;

endpackage

//--- pin_sync.sv
// ----------------------------------------------------------------------
// Two-flop synchroniser for a group of slow pin inputs
// ----------------------------------------------------------------------
module pin_sync #(
	parameter int WIDTH = 4                   // Number of pins synchronised.
) (
	input  wire logic             clk,        // Device clock.
	input  wire logic [WIDTH-1:0] pins_in,    // Raw pin levels.
	output logic      [WIDTH-1:0] pins_out    // Levels safe to read.
);

	// All state of the synchroniser; the first stage feeds only the second.
	typedef struct packed {
		logic [WIDTH-1:0] meta;    // First stage, may go metastable.
		logic [WIDTH-1:0] stable;  // Second stage, read by logic.
	} sync_state_t;

	sync_state_t state;       // Registered state.
	sync_state_t next_state;  // Next value of the state.

	// Shift the pins one stage per clock. No reset is needed: the pins
	// settle within two clocks, and the strap latch reads them on the first clock after reset ends.
	always_comb begin
		next_state        = state;
		next_state.meta   = pins_in;
		next_state.stable = state.meta;
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign pins_out = state.stable;

endmodule

//--- phy_basic_control.sv
module phy_basic_control (
	input  wire logic        CLOCK_IN,           // Device clock, 10 MHz.
	input  wire logic        RST_IN,             // Synchronous reset, active high.
	input  wire logic        WR_EN_IN,           // Management write strobe, one cycle.
	input  wire logic [4:0]  ADDR_IN,            // Management register address.
	input  wire logic [15:0] WDATA_IN,           // Management write data.
	input  wire logic        SPEED_STRAP_IN,     // Speed strapping pin.
	input  wire logic        AUTONEG_ENABLE_STRAP_IN, // Negotiation strapping pin.
	input  wire logic        ISOLATE_STRAP_IN,   // Isolate strapping pin.
	input  wire logic        DUPLEX_STRAP_IN,    // Duplex strapping pin.
	input  wire logic        AN_SPEED_100_IN,    // Negotiated speed, 1 = 100 Mbps.
	input  wire logic        AN_FULL_DUPLEX_IN,  // Negotiated duplex, 1 = full.
	output logic      [15:0] RDATA_OUT,          // Read data for ADDR_IN, one cycle late.
	output logic             SOFT_RESET_OUT,     // One-cycle device reset pulse.
	output logic             AN_RESTART_OUT,     // One-cycle negotiation restart pulse.
	output logic             LOOPBACK_OUT,       // Loopback mode level.
	output logic             COL_TEST_OUT,       // Collision test level.
	output logic             POWER_DOWN_OUT,     // Power-down mode level.
	output logic             ISOLATE_OUT,        // MAC interface isolation level.
	output logic             SPEED_100_OUT,      // Operating speed, 1 = 100 Mbps.
	output logic             FULL_DUPLEX_OUT     // Operating duplex, 1 = full.
);

	// ------------------------------------------------------------------
	// State and helpers
	// ------------------------------------------------------------------

	// All state of the block in one record.
	typedef struct packed {
		phy_ctrl_pkg::mode_t mode;      // Strap latch phase or running.
		logic                loopback;  // Loopback bit.
		logic                speed;     // Manual speed bit.
		logic                an_en;     // Negotiation enable bit.
		logic                pd;        // Power-down bit.
		logic                iso;       // Isolate bit.
		logic                duplex;    // Manual duplex bit.
		logic                col_test;  // Collision test bit.
		logic                sr_pulse;  // Soft reset pulse.
		logic                anr_pulse; // Negotiation restart pulse.
		logic                eff_speed; // Operating speed.
		logic                eff_dup;   // Operating duplex.
		logic [15:0]         rdata;     // Registered read data.
	} ctrl_state_t;

	ctrl_state_t         state;       // Registered state.
	ctrl_state_t         next_state;  // Next value of the state.
	phy_ctrl_pkg::strap_t straps;     // Synchronised strap levels.
	logic                ctrl_wr;     // Write to basic_control this cycle.
	logic [15:0]         ctrl_word;   // Current register image.

	// Straps come from pins, so they pass two flops before any use.
	pin_sync #(
		.WIDTH (phy_ctrl_pkg::STRAP_COUNT)
	) u_strap_sync (
		.clk      (CLOCK_IN),
		.pins_in  ({SPEED_STRAP_IN, AUTONEG_ENABLE_STRAP_IN,
		            ISOLATE_STRAP_IN, DUPLEX_STRAP_IN}),
		.pins_out (straps)
	);

	assign ctrl_wr = WR_EN_IN && (ADDR_IN == phy_ctrl_pkg::BASIC_CONTROL_ADDR);

	// ------------------------------------------------------------------
	// Register image
	// ------------------------------------------------------------------

	// Self-clearing bits always read zero because their pulses last one
	// cycle and are not held in the register image.
	always_comb begin
		ctrl_word                                 = phy_ctrl_pkg::ZERO_WORD;
		ctrl_word[phy_ctrl_pkg::LOOPBACK_BIT]     = state.loopback;
		ctrl_word[phy_ctrl_pkg::SPEED_BIT]        = state.speed;
		ctrl_word[phy_ctrl_pkg::AN_ENABLE_BIT]    = state.an_en;
		ctrl_word[phy_ctrl_pkg::POWER_DOWN_BIT]   = state.pd;
		ctrl_word[phy_ctrl_pkg::ISOLATE_BIT]      = state.iso;
		ctrl_word[phy_ctrl_pkg::DUPLEX_BIT]       = state.duplex;
		ctrl_word[phy_ctrl_pkg::COL_TEST_BIT]     = state.col_test;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// Writes that land in the latch cycle are dropped; the host must wait
	// for that single cycle after any reset.
	always_comb begin
		next_state           = state;
		next_state.sr_pulse  = 1'b0;
		next_state.anr_pulse = 1'b0;
		case (state.mode)
			phy_ctrl_pkg::ST_LATCH: begin
				// Defaults taken from the straps after every reset.
				next_state.speed  = straps.speed_strap;
				next_state.an_en  = straps.autoneg_enable_strap;
				next_state.iso    = straps.isolate_strap;
				next_state.duplex = ~straps.duplex_strap;
				next_state.mode   = phy_ctrl_pkg::ST_RUN;
			end
			phy_ctrl_pkg::ST_RUN: begin
				if (ctrl_wr && WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT] && state.pd) begin
					// Reset write while powered down only wakes the device.
					next_state.pd = 1'b0;
				end else if (ctrl_wr && WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT]) begin
					// Full reset: clear bits, pulse, then re-latch straps.
					next_state.loopback = 1'b0;
					next_state.col_test = 1'b0;
					next_state.pd       = 1'b0;
					next_state.sr_pulse = 1'b1;
					next_state.mode     = phy_ctrl_pkg::ST_LATCH;
				end else if (ctrl_wr) begin
					// Ordinary write of the read-write bits.
					next_state.loopback  = WDATA_IN[phy_ctrl_pkg::LOOPBACK_BIT];
					next_state.speed     = WDATA_IN[phy_ctrl_pkg::SPEED_BIT];
					next_state.an_en     = WDATA_IN[phy_ctrl_pkg::AN_ENABLE_BIT];
					next_state.pd        = WDATA_IN[phy_ctrl_pkg::POWER_DOWN_BIT];
					next_state.iso       = WDATA_IN[phy_ctrl_pkg::ISOLATE_BIT];
					next_state.duplex    = WDATA_IN[phy_ctrl_pkg::DUPLEX_BIT];
					next_state.col_test  = WDATA_IN[phy_ctrl_pkg::COL_TEST_BIT];
					next_state.anr_pulse = WDATA_IN[phy_ctrl_pkg::AN_RESTART_BIT];
				end
			end
			default: begin
				next_state.mode = phy_ctrl_pkg::ST_LATCH;
			end
		endcase
		// Negotiation, when enabled, overrides the manual bits.
		next_state.eff_speed = state.an_en ? AN_SPEED_100_IN : state.speed;
		next_state.eff_dup   = state.an_en ? AN_FULL_DUPLEX_IN : state.duplex;
		// Unmapped addresses read as zero.
		next_state.rdata = (ADDR_IN == phy_ctrl_pkg::BASIC_CONTROL_ADDR) ?
		                   ctrl_word : phy_ctrl_pkg::ZERO_WORD;
	end

	// Register the state; reset enters the strap latch phase.
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			state      <= '0;
			state.mode <= phy_ctrl_pkg::ST_LATCH;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	assign RDATA_OUT       = state.rdata;
	assign SOFT_RESET_OUT  = state.sr_pulse;
	assign AN_RESTART_OUT  = state.anr_pulse;
	assign LOOPBACK_OUT    = state.loopback;
	assign COL_TEST_OUT    = state.col_test;
	assign POWER_DOWN_OUT  = state.pd;
	assign ISOLATE_OUT     = state.iso;
	assign SPEED_100_OUT   = state.eff_speed;
	assign FULL_DUPLEX_OUT = state.eff_dup;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	a_soft_reset_pulse: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT] && !state.pd
		&& state.mode == phy_ctrl_pkg::ST_RUN
		|=> SOFT_RESET_OUT ##1 !SOFT_RESET_OUT)
		else $error("Soft reset did not pulse for one cycle.");

	a_manual_speed_used: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		!state.an_en |=> SPEED_100_OUT == $past(state.speed))
		else $error("Manual speed not applied.");

	a_autoneg_override: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		state.an_en |=> SPEED_100_OUT == $past(AN_SPEED_100_IN)
		&& FULL_DUPLEX_OUT == $past(AN_FULL_DUPLEX_IN))
		else $error("Negotiated result not applied.");

	a_power_down_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && !WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT]
		&& state.mode == phy_ctrl_pkg::ST_RUN
		|=> POWER_DOWN_OUT == $past(WDATA_IN[phy_ctrl_pkg::POWER_DOWN_BIT]))
		else $error("Power-down bit not written.");

	a_pd_wake_only: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT] && state.pd
		&& state.mode == phy_ctrl_pkg::ST_RUN
		|=> !POWER_DOWN_OUT && !SOFT_RESET_OUT && $stable(ISOLATE_OUT))
		else $error("Wake write caused a reset.");

	a_reset_relatch: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		SOFT_RESET_OUT |-> state.mode == phy_ctrl_pkg::ST_LATCH
		##1 state.mode == phy_ctrl_pkg::ST_RUN && state.speed == $past(straps.speed_strap))
		else $error("Straps not re-latched after soft reset.");

	a_isolate_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && !WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT]
		&& state.mode == phy_ctrl_pkg::ST_RUN
		|=> ISOLATE_OUT == $past(WDATA_IN[phy_ctrl_pkg::ISOLATE_BIT]))
		else $error("Isolate bit not written.");

	a_restart_pulse: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && !WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT]
		&& WDATA_IN[phy_ctrl_pkg::AN_RESTART_BIT] && state.mode == phy_ctrl_pkg::ST_RUN
		|=> AN_RESTART_OUT ##1 !AN_RESTART_OUT)
		else $error("Restart did not pulse for one cycle.");

	a_strap_defaults: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		state.mode == phy_ctrl_pkg::ST_LATCH |=> state.an_en == $past(straps.autoneg_enable_strap)
		&& ISOLATE_OUT == $past(straps.isolate_strap))
		else $error("Strap defaults wrong.");

	a_duplex_default: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		state.mode == phy_ctrl_pkg::ST_LATCH |=> state.duplex == !$past(straps.duplex_strap))
		else $error("Duplex default not inverted strap.");

	a_loopback_write: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		ctrl_wr && !WDATA_IN[phy_ctrl_pkg::SOFT_RESET_BIT]
		&& state.mode == phy_ctrl_pkg::ST_RUN
		|=> LOOPBACK_OUT == $past(WDATA_IN[phy_ctrl_pkg::LOOPBACK_BIT]))
		else $error("Loopback bit not written.");

	a_reserved_zero: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		RDATA_OUT[phy_ctrl_pkg::COL_TEST_BIT-1:0] == 7'h00
		&& !RDATA_OUT[phy_ctrl_pkg::SOFT_RESET_BIT] && !RDATA_OUT[phy_ctrl_pkg::AN_RESTART_BIT])
		else $error("Reserved or self-clearing bit read as one.");

endmodule

//--- mgmt_host.sv
// ----------------------------------------------------------------------
// Station manager model: drives management writes and reads
// ----------------------------------------------------------------------
module mgmt_host (
	input  wire logic        clk_in,     // Device clock.
	input  wire logic [15:0] rdata_in,   // Read data from the block.
	output logic             wr_en_out,  // One-cycle write strobe.
	output logic      [4:0]  addr_out,   // Register address.
	output logic      [15:0] wdata_out   // Write data.
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero, so no input of the block floats.
	initial begin
		wr_en_out = 1'b0;
		addr_out  = 5'h00;
		wdata_out = 16'h0000;
	end

	// One write: strobe held for exactly one rising edge.
	// Data is inverted afterwards so a stale word never passes for a fresh one.
	task automatic write(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b1;
		addr_out  = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b0;
		wdata_out = ~d;
	endtask

	// One read: read data is registered, so it is taken two edges later.
	task automatic read(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		@(posedge clk_in);
		@(posedge clk_in);
		#1;
		d = rdata_in;
	endtask
endmodule

//--- tb_phy_basic_control.sv
// ----------------------------------------------------------------------
// Self-checking bench for the basic control register
// ----------------------------------------------------------------------
module tb_phy_basic_control;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk = 1'b0;         // 10 MHz clock.
	logic        rst = 1'b1;         // Synchronous reset.
	logic [3:0]  strap = 4'b1010;    // Speed, negotiation, isolate, duplex straps.
	logic        an_spd = 1'b0;      // Negotiated speed.
	logic        an_fd = 1'b0;       // Negotiated duplex.
	int          n_errors = 0;       // Mismatches.
	int          samples_checked = 0; // Comparisons.
	int          n_soft = 0;         // Soft reset pulses seen.
	int          n_rst = 0;          // Restart pulses seen.
	logic        wr;                 // Write strobe.
	logic [4:0]  addr;               // Address.
	logic [15:0] wdata, rdata;       // Write and read data.
	logic        sr, ar, lb, ct, pd, iso, spd, fd; // Block outputs.

	always #50 clk = ~clk;

	// Pulse counters, so a pulse longer or shorter than one cycle shows up.
	always @(posedge clk) begin
		if (sr === 1'b1) n_soft++;
		if (ar === 1'b1) n_rst++;
	end

	mgmt_host host (.clk_in(clk), .rdata_in(rdata), .wr_en_out(wr), .addr_out(addr),
		.wdata_out(wdata));

	phy_basic_control dut (.CLOCK_IN(clk), .RST_IN(rst), .WR_EN_IN(wr), .ADDR_IN(addr),
		.WDATA_IN(wdata), .SPEED_STRAP_IN(strap[3]), .AUTONEG_ENABLE_STRAP_IN(strap[2]),
		.ISOLATE_STRAP_IN(strap[1]), .DUPLEX_STRAP_IN(strap[0]), .AN_SPEED_100_IN(an_spd),
		.AN_FULL_DUPLEX_IN(an_fd), .RDATA_OUT(rdata), .SOFT_RESET_OUT(sr),
		.AN_RESTART_OUT(ar), .LOOPBACK_OUT(lb), .COL_TEST_OUT(ct), .POWER_DOWN_OUT(pd),
		.ISOLATE_OUT(iso), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fd));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Compare and count; four-state equality keeps unknowns from matching.
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Level outputs packed as loopback, col test, power-down, isolate, speed, duplex.
	function automatic logic [15:0] levels();
		return {10'h000, lb, ct, pd, iso, spd, fd};
	endfunction

	// Register read compared against an expected word.
	task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
		logic [15:0] d;
		host.read(a, d);
		check(d, exp, what);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------

	// Strap-derived reset values with self-clearing bits at zero.
	task automatic t_defaults;
		rd(5'h00, 16'h2500, "reset word");
		check(levels(), 16'h0007, "reset levels");
	endtask

	// Plain fields, reserved bits written as ones read back zero.
	task automatic t_levels;
		host.write(5'h00, 16'h40FF);
		@(posedge clk);
		#1;
		check(levels(), 16'h0030, "loop col levels");
		rd(5'h00, 16'h4080, "reserved read");
	endtask

	// Negotiated result overrides manual bits; restart pulses once.
	task automatic t_autoneg;
		int r0;
		r0 = n_rst;
		an_spd = 1'b1;
		host.write(5'h00, 16'h1200);
		@(posedge clk);
		#1;
		check(levels(), 16'h0002, "negotiated 100 half");
		check(16'(n_rst - r0), 16'h0001, "restart pulse");
		rd(5'h00, 16'h1000, "restart self clear");
		an_spd = 1'b0;
		an_fd = 1'b1;
		host.write(5'h00, 16'h3100);
		@(posedge clk);
		#1;
		check(levels(), 16'h0001, "manual speed ignored");
	endtask

	// Unmapped writes are dropped and unmapped reads give zero.
	task automatic t_unmapped;
		host.write(5'h01, 16'hFFFF);
		rd(5'h00, 16'h3100, "unmapped write");
		rd(5'h01, 16'h0000, "unmapped read");
	endtask

	// Two-write exit from power-down: wake first, then full reset.
	task automatic t_power;
		int s0;
		host.write(5'h00, 16'h4800);
		// Speed and duplex follow the manual bits one cycle after the write.
		@(posedge clk);
		#1;
		check(levels(), 16'h0020 | 16'h0008, "power down");
		strap = 4'b0101;
		s0 = n_soft;
		host.write(5'h00, 16'h8000);
		// Let a wrongly issued pulse reach the counter before it is judged.
		repeat (2) @(posedge clk);
		#1;
		check(levels() & 16'h0028, 16'h0020, "first write wakes");
		check(16'(n_soft - s0), 16'h0000, "no reset on wake");
		host.write(5'h00, 16'h8000);
		repeat (3) @(posedge clk);
		#1;
		check(16'(n_soft - s0), 16'h0001, "second write resets");
		rd(5'h00, 16'h1000, "straps relatched");
	endtask

	// ------------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------------

	task automatic results;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// The whole run is about fifty cycles; a thousand means a hang.
	initial begin
		#100000;
		n_errors++;
		results();
	end

	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (3) @(posedge clk);
		t_defaults();
		t_levels();
		t_autoneg();
		t_unmapped();
		t_power();
		results();
	end
endmodule
